// [hdl/rcb_pkg.sv]
/*
 rcb_pkg: shared constants and types of the receiver control board glue.
 assumes a 50 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package rcb_pkg;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int XTAL_HZ = 2_000_000;
	localparam int PHASE_DIV = CLK_HZ / XTAL_HZ;
	localparam int PH_W = 5;
	localparam logic [PH_W-1:0] PH_LAST = PH_W'(PHASE_DIV - 1);
	localparam int POR_NS = 1000;
	localparam int POR_CYC = (POR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [7:0] POR_LAST = 8'(POR_CYC - 1);
	localparam logic [2:0] SHORT_PERIODS = 3'h4;
	localparam logic [2:0] LONG_PERIODS = 3'h6;
	// ==========================================================
	// operation codes
	localparam logic [4:0] OP_FETCH = 5'h00;
	localparam logic [4:0] OP_PC_LO = 5'h01;
	localparam logic [4:0] OP_PC_HI = 5'h02;
	localparam logic [4:0] OP_DC_LOAD = 5'h03;
	localparam logic [4:0] OP_MEM_RD = 5'h04;
	localparam logic [4:0] OP_MEM_WR = 5'h05;
	localparam logic [4:0] OP_IO_ADDR = 5'h06;
	localparam logic [4:0] OP_IO_RD = 5'h07;
	localparam logic [4:0] OP_IO_WR = 5'h08;
	localparam logic [4:0] OP_INT_VEC = 5'h09;
	localparam logic [4:0] OP_IDLE = 5'h1f;
	// ==========================================================
	// memory map
	localparam int ADDR_W = 13;
	localparam int ROM_COUNT = 3;
	localparam logic [1:0] RAM_SEL = 2'h3;
	localparam int IOSEL_SW_BIT = 7;
	// ==========================================================
	// cpu i/o port indices: port 0k is k, port 1k is 8+k
	localparam int IOP_INH_RX = 0;
	localparam int IOP_INH_TX = 1;
	localparam int IOP_TX_EMPTY = 8;
	localparam int IOP_RX_READY = 9;
	localparam int IOP_FRAMING = 10;
	localparam int IOP_OVERRUN = 11;
	localparam int IOP_PARITY = 12;
	// ==========================================================
	// registers
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TIMER = 8'h04;
	localparam logic [7:0] REG_VECTOR = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_COUNT = 8'h10;
	localparam logic [7:0] REG_IOSEL = 8'h14;
	localparam int CTRL_SERIAL_BIT = 0;
	localparam int CTRL_TIMER_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h2;
	localparam logic [15:0] TIMER_RST = 16'h00ff;
	localparam logic [12:0] VECTOR_RST = 13'h0020;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		PWR_OFF, PWR_MEM_ON, PWR_RUN, PWR_STOPPING, PWR_RETAIN
	} rcb_pwr_t;
endpackage

// [hdl/rcb_top.sv]
/*
 rcb_top: glue logic of the receiver control microcomputer board.
 assumes the cpu core and memories sit on core_clk; supply, serial module
 and i/o bus pins are asynchronous and are synchronised here.
*/
// Implementation choices: the address map and the AXI4-Lite register port.
// What this block does
// - phase clock and write pulse from 2.0 MHz
// - one 8-bit two-way cpu data bus
// - five-line operation code steers each cycle
// - cycles last four or six phase periods
// - three 2K program roms, upper-address chip selects
// - ram pair: low and high nibbles
// - eleven address lines, top two decoded
// - memory read or write strobe per code
// - program counter increments or loads; data counter
// - timer raises internal interrupt requests
// - gated bidirectional switch to i/o bus
// - active-low i/o read and write strobes
// - 8-bit i/o select latch from data bus
// - power-on: reset high, ram on, cpu released
// - supply fall: reset low, cpu stop request
// - after power loss, ram retention mode
// - active-low request, block output stops nesting
// - no serial module: block feeds priority input
// - serial fitted: its priority output chains in
// - rx ready, tx empty on ports 11, 10
// - parity, overrun, framing on ports 14,13,12
// - two port lines go to serial module
`timescale 1ns/1ps
module rcb_top (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic phase_clk,
	output logic write_pulse,
	input wire logic [4:0] cpu_operation_code,
	input wire logic [7:0] cpu_data_in,
	output logic [7:0] cpu_data_out,
	output logic cpu_data_oe_n,
	input wire logic [15:0] cpu_port_out,
	output logic [15:0] cpu_port_in,
	input wire logic interrupt_block_n,
	output logic cpu_int_req_n,
	output logic [10:0] mem_addr,
	output logic [2:0] rom_ce_n,
	output logic ram_ce_n,
	output logic mem_read_n,
	output logic mem_write_n,
	input wire logic [7:0] rom_data,
	input wire logic [3:0] ram_lo_data,
	input wire logic [3:0] ram_hi_data,
	output logic [3:0] ram_lo_wdata,
	output logic [3:0] ram_hi_wdata,
	input wire logic [7:0] io_data_in,
	output logic [7:0] io_data_out,
	output logic io_data_oe_n,
	output logic [7:0] io_select_code,
	output logic io_select_oe_n,
	output logic io_read_strobe_n,
	output logic io_write_strobe_n,
	input wire logic supply_ok,
	output logic board_reset_n,
	output logic memory_mode_select,
	output logic cpu_reset_n,
	output logic cpu_stop_req,
	input wire logic serial_int_req_n,
	input wire logic serial_pri_out_n,
	input wire logic rx_data_ready,
	input wire logic tx_buffer_empty,
	input wire logic parity_error_flag,
	input wire logic overrun_error_flag,
	input wire logic framing_error_flag,
	output logic serial_block_n,
	output logic [1:0] serial_inhibit
);
	// ==========================================================
	// reset and input synchronisers
	logic rst_meta_ff, rst_n;
	logic [15:0] sync1_ff, sync2_ff;
	logic supply_s, ser_int_n_s, ser_pri_n_s;
	logic [7:0] io_data_s;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= 16'h0000;
			sync2_ff <= 16'h0000;
		end else begin
			sync1_ff <= {io_data_in, supply_ok, serial_int_req_n,
				serial_pri_out_n, rx_data_ready, tx_buffer_empty,
				parity_error_flag, overrun_error_flag,
				framing_error_flag};
			sync2_ff <= sync1_ff;
		end
	end
	assign io_data_s = sync2_ff[15:8];
	assign supply_s = sync2_ff[7];
	assign ser_int_n_s = sync2_ff[6];
	assign ser_pri_n_s = sync2_ff[5];

	// ==========================================================
	// registers held by software
	logic [1:0] ctrl_ff;
	logic [15:0] timer_reload_ff;
	logic [12:0] vector_ff;
	logic fitted;
	assign fitted = ctrl_ff[rcb_pkg::CTRL_SERIAL_BIT];

	// ==========================================================
	// phase clock and instruction cycle
	logic [rcb_pkg::PH_W-1:0] ph_cnt_ff;
	logic phase_en, phase_clk_ff;
	logic [2:0] period_ff, cyc_last;
	logic [4:0] op_ff;
	logic exec;
	rcb_pkg::rcb_pwr_t pwr_ff;
	assign phase_en = (ph_cnt_ff == rcb_pkg::PH_LAST);
	always_comb begin
		unique case (op_ff)
			rcb_pkg::OP_PC_LO, rcb_pkg::OP_PC_HI:
				cyc_last = rcb_pkg::LONG_PERIODS - 3'h1;
			default: cyc_last = rcb_pkg::SHORT_PERIODS - 3'h1;
		endcase
	end
	assign write_pulse = phase_en && (period_ff == cyc_last);
	assign phase_clk = phase_clk_ff;
	assign exec = (pwr_ff == rcb_pkg::PWR_RUN) ||
		(pwr_ff == rcb_pkg::PWR_STOPPING);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_cnt_ff <= '0;
			phase_clk_ff <= 1'b0;
			period_ff <= 3'h0;
			op_ff <= rcb_pkg::OP_IDLE;
		end else begin
			ph_cnt_ff <= phase_en ? '0 : ph_cnt_ff + 1'b1;
			phase_clk_ff <= phase_en;
			if (phase_en)
				period_ff <= write_pulse ? 3'h0 : period_ff + 3'h1;
			if (write_pulse)
				op_ff <= exec ? cpu_operation_code : rcb_pkg::OP_IDLE;
		end
	end

	// ==========================================================
	// program and data counters, memory decode
	logic [12:0] pc_ff;
	logic [7:0] dc_ff;
	logic [12:0] addr;
	logic op_pc_mem, op_dc_mem, tmr_pend_ff, tmr_ack;
	logic [7:0] mem_rdata;
	logic [10:0] mem_addr_ff;
	logic [2:0] rom_ce_n_ff;
	logic ram_ce_n_ff, mem_read_n_ff, mem_write_n_ff;
	logic [7:0] ram_wdata_ff;
	assign op_pc_mem = (op_ff == rcb_pkg::OP_FETCH);
	assign op_dc_mem = (op_ff == rcb_pkg::OP_MEM_RD) ||
		(op_ff == rcb_pkg::OP_MEM_WR);
	assign addr = op_dc_mem ? {rcb_pkg::RAM_SEL, 3'h0, dc_ff} : pc_ff;
	assign tmr_ack = write_pulse && exec && (op_ff == rcb_pkg::OP_INT_VEC);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_ff <= '0;
			dc_ff <= 8'h00;
		end else if (write_pulse && exec) begin
			unique case (op_ff)
				rcb_pkg::OP_FETCH: pc_ff <= pc_ff + 13'h0001;
				rcb_pkg::OP_PC_LO: pc_ff[7:0] <= cpu_data_in;
				rcb_pkg::OP_PC_HI: pc_ff[12:8] <= cpu_data_in[4:0];
				rcb_pkg::OP_INT_VEC: pc_ff <= vector_ff;
				rcb_pkg::OP_DC_LOAD: dc_ff <= cpu_data_in;
				rcb_pkg::OP_MEM_RD, rcb_pkg::OP_MEM_WR:
					dc_ff <= dc_ff + 8'h01;
				default: ;
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_addr_ff <= 11'h000;
			rom_ce_n_ff <= 3'h7;
			ram_ce_n_ff <= 1'b1;
			mem_read_n_ff <= 1'b1;
			mem_write_n_ff <= 1'b1;
			ram_wdata_ff <= 8'h00;
		end else begin
			mem_addr_ff <= addr[10:0];
			for (int i = 0; i < rcb_pkg::ROM_COUNT; i++)
				rom_ce_n_ff[i] <= !(exec && op_pc_mem &&
					addr[12:11] == 2'(i));
			ram_ce_n_ff <= !(exec && op_dc_mem);
			mem_read_n_ff <= !(exec && (op_pc_mem ||
				op_ff == rcb_pkg::OP_MEM_RD));
			mem_write_n_ff <= !(write_pulse && exec &&
				op_ff == rcb_pkg::OP_MEM_WR);
			if (write_pulse)
				ram_wdata_ff <= cpu_data_in;
		end
	end
	assign mem_addr = mem_addr_ff;
	assign rom_ce_n = rom_ce_n_ff;
	assign ram_ce_n = ram_ce_n_ff;
	assign mem_read_n = mem_read_n_ff;
	assign mem_write_n = mem_write_n_ff;
	assign ram_lo_wdata = ram_wdata_ff[3:0];
	assign ram_hi_wdata = ram_wdata_ff[7:4];
	assign mem_rdata = op_dc_mem ? {ram_hi_data, ram_lo_data} : rom_data;

	// ==========================================================
	// i/o select latch, switch and strobes
	logic [7:0] iosel_ff, cpu_dout_ff, io_dout_ff;
	logic iosel_vld_ff, sw_en, cpu_oe_n_ff, io_oe_n_ff, iord_n_ff, iowr_n_ff;
	assign sw_en = exec && iosel_ff[rcb_pkg::IOSEL_SW_BIT] &&
		(op_ff == rcb_pkg::OP_IO_RD || op_ff == rcb_pkg::OP_IO_WR);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			iosel_ff <= 8'h00;
			iosel_vld_ff <= 1'b0;
		end else if (write_pulse && exec && op_ff == rcb_pkg::OP_IO_ADDR) begin
			iosel_ff <= cpu_data_in;
			iosel_vld_ff <= 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_dout_ff <= 8'h00;
			cpu_oe_n_ff <= 1'b1;
			io_dout_ff <= 8'h00;
			io_oe_n_ff <= 1'b1;
			iord_n_ff <= 1'b1;
			iowr_n_ff <= 1'b1;
		end else begin
			cpu_dout_ff <= (op_ff == rcb_pkg::OP_IO_RD) ? io_data_s : mem_rdata;
			cpu_oe_n_ff <= !((sw_en && op_ff == rcb_pkg::OP_IO_RD) ||
				(exec && !mem_read_n_ff));
			io_dout_ff <= cpu_data_in;
			io_oe_n_ff <= !(sw_en && op_ff == rcb_pkg::OP_IO_WR);
			iord_n_ff <= !(sw_en && op_ff == rcb_pkg::OP_IO_RD);
			iowr_n_ff <= !(sw_en && op_ff == rcb_pkg::OP_IO_WR);
		end
	end
	assign cpu_data_out = cpu_dout_ff;
	assign cpu_data_oe_n = cpu_oe_n_ff;
	assign io_data_out = io_dout_ff;
	assign io_data_oe_n = io_oe_n_ff;
	assign io_read_strobe_n = iord_n_ff;
	assign io_write_strobe_n = iowr_n_ff;
	assign io_select_code = iosel_ff;
	assign io_select_oe_n = !iosel_vld_ff;

	// ==========================================================
	// timer, interrupt and priority chain
	logic [15:0] tmr_ff;
	logic priority_chain_in_n_n;
	assign priority_chain_in_n_n = fitted ? ser_pri_n_s : interrupt_block_n;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_ff <= rcb_pkg::TIMER_RST;
			tmr_pend_ff <= 1'b0;
		end else begin
			if (phase_en)
				tmr_ff <= (tmr_ff == 16'h0000) ? timer_reload_ff :
					tmr_ff - 16'h0001;
			// a new expiry wins over the acknowledge in the same cycle
			if (phase_en && tmr_ff == 16'h0000 && priority_chain_in_n_n &&
				ctrl_ff[rcb_pkg::CTRL_TIMER_BIT])
				tmr_pend_ff <= 1'b1;
			else if (tmr_ack)
				tmr_pend_ff <= 1'b0;
		end
	end
	assign cpu_int_req_n = !tmr_pend_ff && (!fitted || ser_int_n_s);
	assign serial_block_n = fitted ? interrupt_block_n : 1'b1;
	always_comb begin
		cpu_port_in = 16'h0000;
		if (fitted) begin
			cpu_port_in[rcb_pkg::IOP_RX_READY] = sync2_ff[4];
			cpu_port_in[rcb_pkg::IOP_TX_EMPTY] = sync2_ff[3];
			cpu_port_in[rcb_pkg::IOP_PARITY] = sync2_ff[2];
			cpu_port_in[rcb_pkg::IOP_OVERRUN] = sync2_ff[1];
			cpu_port_in[rcb_pkg::IOP_FRAMING] = sync2_ff[0];
		end
	end
	assign serial_inhibit = fitted ? {cpu_port_out[rcb_pkg::IOP_INH_TX],
		cpu_port_out[rcb_pkg::IOP_INH_RX]} : 2'h0;

	// ==========================================================
	// power sequencing
	logic [7:0] por_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_ff <= rcb_pkg::PWR_OFF;
			por_ff <= 8'h00;
		end else begin
			por_ff <= (pwr_ff == rcb_pkg::PWR_MEM_ON) ? por_ff + 8'h01 : 8'h00;
			unique case (pwr_ff)
				rcb_pkg::PWR_OFF, rcb_pkg::PWR_RETAIN:
					if (supply_s) pwr_ff <= rcb_pkg::PWR_MEM_ON;
				rcb_pkg::PWR_MEM_ON:
					if (!supply_s) pwr_ff <= rcb_pkg::PWR_RETAIN;
					else if (por_ff == rcb_pkg::POR_LAST)
						pwr_ff <= rcb_pkg::PWR_RUN;
				rcb_pkg::PWR_RUN:
					if (!supply_s) pwr_ff <= rcb_pkg::PWR_STOPPING;
				rcb_pkg::PWR_STOPPING:
					if (write_pulse) pwr_ff <= rcb_pkg::PWR_RETAIN;
			endcase
		end
	end
	assign board_reset_n = (pwr_ff == rcb_pkg::PWR_MEM_ON) ||
		(pwr_ff == rcb_pkg::PWR_RUN);
	assign memory_mode_select = (pwr_ff != rcb_pkg::PWR_OFF) &&
		(pwr_ff != rcb_pkg::PWR_RETAIN);
	assign cpu_reset_n = exec;
	assign cpu_stop_req = (pwr_ff == rcb_pkg::PWR_STOPPING);

	// ==========================================================
	// axi4-lite slave
	logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic wr_go, wr_hit;
	assign s_axi_awready = !aw_ff && !bvalid_ff;
	assign s_axi_wready = !w_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign wr_go = aw_ff && w_ff && !bvalid_ff;
	assign wr_hit = awaddr_ff == rcb_pkg::REG_CTRL ||
		awaddr_ff == rcb_pkg::REG_TIMER || awaddr_ff == rcb_pkg::REG_VECTOR;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			bvalid_ff <= 1'b0;
			bresp_ff <= rcb_pkg::RESP_OKAY;
			ctrl_ff <= rcb_pkg::CTRL_RST;
			timer_reload_ff <= rcb_pkg::TIMER_RST;
			vector_ff <= rcb_pkg::VECTOR_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ff <= 1'b1;
				awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_ff <= 1'b0;
				w_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit ? rcb_pkg::RESP_OKAY : rcb_pkg::RESP_SLVERR;
				if (awaddr_ff == rcb_pkg::REG_CTRL)
					ctrl_ff <= wdata_ff[1:0];
				if (awaddr_ff == rcb_pkg::REG_TIMER)
					timer_reload_ff <= wdata_ff[15:0];
				if (awaddr_ff == rcb_pkg::REG_VECTOR)
					vector_ff <= wdata_ff[12:0];
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= rcb_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= rcb_pkg::RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'h0})
				rcb_pkg::REG_CTRL: rdata_ff <= {30'h0, ctrl_ff};
				rcb_pkg::REG_TIMER: rdata_ff <= {16'h0, timer_reload_ff};
				rcb_pkg::REG_VECTOR: rdata_ff <= {19'h0, vector_ff};
				rcb_pkg::REG_STATUS: rdata_ff <= {24'h0, priority_chain_in_n_n,
					tmr_pend_ff, supply_s, 2'h0, pwr_ff};
				rcb_pkg::REG_COUNT: rdata_ff <= {3'h0, pc_ff, 8'h0, dc_ff};
				rcb_pkg::REG_IOSEL: rdata_ff <= {19'h0, op_ff, iosel_ff};
				default: begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= rcb_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// ==========================================================
	// assertions
	localparam int PH_I = rcb_pkg::PHASE_DIV;
	logic [3:0] per_seen_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) per_seen_ff <= 4'h0;
		else if (write_pulse) per_seen_ff <= 4'h0;
		else if (phase_en) per_seen_ff <= per_seen_ff + 4'h1;
	end
	phase_rate_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) phase_en |-> ##PH_I phase_en)
		else $error("phase rate wrong");
	cycle_len_a: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		write_pulse && $past(write_pulse, 1) == 1'b0 && per_seen_ff != 4'h0 |->
		per_seen_ff + 4'h1 == ((op_ff == rcb_pkg::OP_PC_LO ||
		op_ff == rcb_pkg::OP_PC_HI) ? 4'h6 : 4'h4))
		else $error("cycle length wrong");
	chip_sel_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) $onehot0(~{rom_ce_n, ram_ce_n}))
		else $error("two chips selected");
	mem_write_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) !mem_write_n |->
		$past(write_pulse) && $past(op_ff) == rcb_pkg::OP_MEM_WR)
		else $error("stray memory write");
	pc_step_a: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		write_pulse && exec && op_ff == rcb_pkg::OP_FETCH |=>
		pc_ff == $past(pc_ff) + 13'h0001) else $error("pc did not step");
	io_latch_a: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		write_pulse && exec && op_ff == rcb_pkg::OP_IO_ADDR |=>
		io_select_code == $past(cpu_data_in) ##1 !io_select_oe_n)
		else $error("select latch missed");
	io_strobe_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) !io_read_strobe_n || !io_write_strobe_n |->
		io_select_code[rcb_pkg::IOSEL_SW_BIT] &&
		io_read_strobe_n != io_write_strobe_n)
		else $error("bad i/o strobe");
	prio_block_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) !priority_chain_in_n_n && !tmr_pend_ff |=> !tmr_pend_ff)
		else $error("timer ignored priority");
	power_fail_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) pwr_ff == rcb_pkg::PWR_RUN && !supply_s |=>
		!board_reset_n && cpu_stop_req)
		else $error("power fail not handled");
	retain_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) cpu_stop_req && write_pulse |=>
		!memory_mode_select && !cpu_reset_n)
		else $error("no retention mode");
	// flags must be the pins as seen two edges earlier, in port order
	flags_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) fitted |->
		cpu_port_in[rcb_pkg::IOP_RX_READY] == $past(rx_data_ready, 2) &&
		cpu_port_in[rcb_pkg::IOP_PARITY] == $past(parity_error_flag, 2))
		else $error("serial flags misplaced");
	fetch_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		write_pulse && exec && op_ff == rcb_pkg::OP_FETCH);
	ioread_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		!io_read_strobe_n);
	timer_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		$rose(tmr_pend_ff));
	fail_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		pwr_ff == rcb_pkg::PWR_RETAIN);
endmodule

// [tb/rcb_serial_model.sv]
/*
 rcb_serial_model: behavioural serial interface module at the far side.
 assumes the bench sets its flags and request; outputs are plain levels.
*/
`timescale 1ns/1ps
module rcb_serial_model (
	input wire logic [4:0] flags,
	input wire logic req,
	input wire logic block_n,
	output logic int_req_n,
	output logic pri_out_n,
	output logic [4:0] flag_out
);
	// order: parity, overrun, framing, rx ready, tx empty
	assign flag_out = flags;
	// requests only while the cpu is not blocking
	assign int_req_n = ~(req & block_n);
	// priority is held off while a request waits or the cpu blocks
	assign pri_out_n = ~req & block_n;
endmodule

// [tb/receiver_control_cpu_board_tb_top.sv]
/*
 receiver_control_cpu_board_tb_top: self-checking bench of the board glue.
 assumes rcb_top and the serial module model; axi4-lite master here.
*/
`timescale 1ns/1ps
module receiver_control_cpu_board_tb_top;
	// ==========================================================
	// signals
	logic core_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, phase_clk;
	logic write_pulse, cpu_data_oe_n, interrupt_block_n, cpu_int_req_n;
	logic ram_ce_n, mem_read_n, mem_write_n, io_data_oe_n, io_select_oe_n;
	logic io_read_strobe_n, io_write_strobe_n, supply_ok, board_reset_n;
	logic memory_mode_select, cpu_reset_n, cpu_stop_req, serial_int_req_n;
	logic serial_pri_out_n, rx_data_ready, tx_buffer_empty, serial_block_n;
	logic parity_error_flag, overrun_error_flag, framing_error_flag, req;
	logic [7:0] s_axi_awaddr, s_axi_araddr, cpu_data_in, cpu_data_out;
	logic [7:0] rom_data, io_data_in, io_data_out, io_select_code;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0] s_axi_wstrb, ram_lo_data, ram_hi_data;
	logic [3:0] ram_lo_wdata, ram_hi_wdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, serial_inhibit, r, sn;
	logic [4:0] cpu_operation_code, flags, mw;
	logic [15:0] cpu_port_out, cpu_port_in;
	logic [10:0] mem_addr;
	logic [2:0] rom_ce_n;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	rcb_top dut (.*);
	rcb_serial_model far (.flags(flags), .req(req),
		.block_n(serial_block_n), .int_req_n(serial_int_req_n),
		.pri_out_n(serial_pri_out_n), .flag_out({parity_error_flag,
		overrun_error_flag, framing_error_flag, rx_data_ready,
		tx_buffer_empty}));
	// ==========================================================
	// common tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic axi(input bit wr, input logic [7:0] a,
		input logic [31:0] d);
		bit aw, w, ar, dn;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_arvalid <= !wr;
		s_axi_bready <= wr;
		s_axi_rready <= !wr;
		do begin
			@(negedge core_clk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			ar = s_axi_arvalid & s_axi_arready;
			dn = wr ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			r = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge core_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (ar) s_axi_arvalid <= 1'b0;
		end while (!dn);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs();
		axi(0, rcb_pkg::REG_CTRL, 0);
		chk(q, 32'h2);
		axi(0, rcb_pkg::REG_VECTOR, 0);
		chk(q, 32'h20);
		axi(1, 8'h40, 32'h5);
		chk(32'(r), 32'(rcb_pkg::RESP_SLVERR));
		axi(0, 8'h40, 0);
		chk(32'(r), 32'(rcb_pkg::RESP_SLVERR));
		$display("done regs");
	endtask
	task automatic t_power();
		@(posedge core_clk);
		supply_ok <= 1'b1;
		tick(8);
		chk(32'({board_reset_n, memory_mode_select, cpu_reset_n}), 6);
		tick(60);
		chk(32'(cpu_reset_n), 1);
		$display("done power");
	endtask
	task automatic t_serial();
		axi(1, rcb_pkg::REG_CTRL, 32'h1);
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk);
			cpu_port_out <= 16'h0002;
			flags <= i ? 5'h0a : 5'h15;
			tick(4);
			chk(32'(cpu_port_in), i ? 32'h0a00 : 32'h1500);
		end
		chk(32'(serial_inhibit), 2);
		@(posedge core_clk);
		req <= 1'b1;
		tick(4);
		chk(32'({serial_block_n, cpu_int_req_n}), 2);
		@(posedge core_clk);
		interrupt_block_n <= 1'b0;
		tick(4);
		chk(32'({serial_block_n, cpu_int_req_n}), 1);
		@(posedge core_clk);
		req <= 1'b0;
		interrupt_block_n <= 1'b1;
		axi(1, rcb_pkg::REG_CTRL, 32'h0);
		tick(4);
		chk({cpu_port_in, 13'h0, serial_block_n, serial_inhibit}, 4);
		$display("done serial");
	endtask
	task automatic t_io();
		@(posedge core_clk);
		cpu_operation_code <= rcb_pkg::OP_IO_ADDR;
		cpu_data_in <= 8'h85;
		tick(300);
		chk({io_select_code, io_select_oe_n}, 32'h10a);
		@(posedge core_clk);
		cpu_operation_code <= rcb_pkg::OP_IO_WR;
		sn = 2'b00;
		repeat (300) begin
			tick(1);
			sn |= ~{io_write_strobe_n, io_data_oe_n};
		end
		chk(32'(sn), 3);
		@(posedge core_clk);
		cpu_operation_code <= rcb_pkg::OP_IDLE;
		$display("done io");
	endtask
	task automatic t_timer();
		axi(1, rcb_pkg::REG_TIMER, 32'h2);
		axi(1, rcb_pkg::REG_CTRL, 32'h2);
		interrupt_block_n <= 1'b0;
		sn = 2'b00;
		for (int n = 0; n < 7000; n++) begin
			tick(1);
			sn[0] |= !cpu_int_req_n;
		end
		chk(32'(sn), 0);
		@(posedge core_clk);
		interrupt_block_n <= 1'b1;
		for (int n = 0; n < 7000 && cpu_int_req_n !== 1'b0; n++)
			tick(1);
		chk(32'(cpu_int_req_n), 0);
		$display("done timer");
	endtask
	// waits for the edge that takes the current code, then offers c
	task automatic op(input logic [4:0] c);
		do begin
			@(negedge core_clk);
			mw |= ~{cpu_data_oe_n, mem_write_n, rom_ce_n[0], ram_ce_n,
				io_read_strobe_n};
		end while (write_pulse !== 1'b1);
		@(posedge core_clk);
		cpu_operation_code <= c;
	endtask
	task automatic t_mem();
		mw = 5'h00;
		op(rcb_pkg::OP_INT_VEC);
		op(rcb_pkg::OP_FETCH);
		op(rcb_pkg::OP_PC_LO);
		op(rcb_pkg::OP_DC_LOAD);
		op(rcb_pkg::OP_MEM_WR);
		op(rcb_pkg::OP_MEM_RD);
		op(rcb_pkg::OP_IO_RD);
		op(rcb_pkg::OP_IDLE);
		op(rcb_pkg::OP_IDLE);
		tick(0);
		chk(32'(mw), 32'h1f);
		chk(32'({io_data_out, ram_hi_wdata, ram_lo_wdata}), 32'h8585);
		axi(0, rcb_pkg::REG_COUNT, 0);
		chk(q, 32'h0085_0087);
		$display("done mem");
	endtask
	task automatic t_fail();
		@(posedge core_clk);
		supply_ok <= 1'b0;
		tick(6);
		chk(32'({board_reset_n, cpu_stop_req}), 1);
		tick(200);
		chk(32'({memory_mode_select, cpu_reset_n}), 0);
		$display("done fail");
	endtask
	// ==========================================================
	// clock, watchdog, main sequence
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 25000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, supply_ok, req, rstn, flags} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, cpu_data_in} = '0;
		{rom_data, io_data_in, ram_lo_data, ram_hi_data} = '0;
		cpu_port_out = 16'h0000;
		s_axi_wstrb = 4'hf;
		cpu_operation_code = rcb_pkg::OP_IDLE;
		interrupt_block_n = 1'b1;
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_regs();
		t_power();
		t_serial();
		t_io();
		t_timer();
		t_mem();
		t_fail();
		stop_test();
	end
endmodule
